/* File: hw/xzd_io_zone_decode.sv */
// I/O zone decode configuration: lockable map registers on AXI4-Lite and the zone select decoder.
// Assumes io_req/io_addr come from logic on aclk; power-up reset inputs come from pins.
`timescale 1ns/100ps
`default_nettype none
`include "xzd_defines.svh"

module xzd_io_zone_decode
    import xzd_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        main_power_up_reset,
    input  wire logic        standby_power_up_reset,
    input  wire logic        io_req,
    input  wire logic [15:0] io_addr,
    input  wire logic [4:0]  ext_chip_selects,
    output logic [4:0]       zone_select,
    output logic             io_forward
);

    xzd_byte_t     cfg_r, a_high_r, a_low_r, a_size_r, b_high_r, b_low_r, b_size_r;
    logic          stby_sel_r;
    xzd_wr_state_t wr_state_r;
    logic          aw_done_r, w_done_r, awready_r, wready_r, arready_r, rvalid_r;
    logic [7:0]    aw_idx_r;
    xzd_byte_t     wbyte_r;
    logic          wlane_r;
    logic [1:0]    bresp_r, rresp_r;
    logic [31:0]   rdata_r;
    logic [1:0]    main_sync_r, stby_sync_r;
    logic [4:0]    zone_sel_r;
    logic          io_fwd_r;

    // Register read and write decoding
    function automatic logic idx_mapped(input logic [7:0] idx);
        return (idx >= `XZD_IDX_CFG && idx <= `XZD_IDX_B_SIZE) || idx == `XZD_IDX_LOCK_CTL;
    endfunction : idx_mapped

    wire logic aw_hs   = s_axi_awvalid && awready_r;
    wire logic w_hs    = s_axi_wvalid && wready_r;
    wire logic b_hs    = wr_state_r[1] && s_axi_bready;
    wire logic ar_hs   = s_axi_arvalid && arready_r;
    wire logic r_hs    = rvalid_r && s_axi_rready;
    wire logic wr_fire = aw_done_r && w_done_r && wr_state_r[0];
    wire logic wr_en   = wr_fire && wlane_r;
    wire logic locked  = cfg_r[`XZD_LOCK_BIT];
    wire logic map_wr  = wr_en && !locked;

    // Lock release sources; release wins over a simultaneous write of the lock
    wire logic unlock_wr   = wr_en && aw_idx_r == `XZD_IDX_LOCK_CTL && wbyte_r[`XZD_UNLOCK_BIT];
    wire logic por_release = stby_sel_r ? stby_sync_r[1] : main_sync_r[1];
    wire logic lock_clr    = unlock_wr || por_release;

    wire xzd_byte_t cfg_nxt  = (map_wr && aw_idx_r == `XZD_IDX_CFG) ? (wbyte_r & `XZD_CFG_WR_MASK) : cfg_r;
    wire xzd_byte_t cfg_fin  = lock_clr ? (cfg_nxt & ~(8'h01 << `XZD_LOCK_BIT)) : cfg_nxt;

    wire logic [7:0] ar_idx  = s_axi_araddr[9:2];
    wire logic       ar_ok   = idx_mapped(ar_idx) && s_axi_araddr[11:10] == 2'h0 && s_axi_araddr[1:0] == 2'h0;
    wire logic       aw_ok   = idx_mapped(aw_idx_r);

    wire xzd_byte_t rd_byte =
        (ar_idx == `XZD_IDX_CFG)         ? cfg_r    :
        (ar_idx == `XZD_IDX_A_BASE_HIGH) ? a_high_r :
        (ar_idx == `XZD_IDX_A_BASE_LOW)  ? a_low_r  :
        (ar_idx == `XZD_IDX_A_SIZE)      ? a_size_r :
        (ar_idx == `XZD_IDX_B_BASE_HIGH) ? b_high_r :
        (ar_idx == `XZD_IDX_B_BASE_LOW)  ? b_low_r  :
        (ar_idx == `XZD_IDX_B_SIZE)      ? b_size_r :
        (ar_idx == `XZD_IDX_LOCK_CTL)    ? {6'h00, stby_sel_r, 1'b0} : 8'h00;

    // Zone decode
    logic hit0, hit1, hit2, hit3;

    xzd_zone_pair pair_a
    (
        .base_high (a_high_r),
        .base_low  (a_low_r),
        .size_exp  (a_size_r[3:0]),
        .io_addr   (io_addr),
        .hit_lower (hit0),
        .hit_upper (hit1)
    );

    xzd_zone_pair pair_b
    (
        .base_high (b_high_r),
        .base_low  (b_low_r),
        .size_exp  (b_size_r[3:0]),
        .io_addr   (io_addr),
        .hit_lower (hit2),
        .hit_upper (hit3)
    );

    wire logic       dbg_hit  = io_addr == `XZD_DEBUG_PORT_ADDR;
    wire logic [4:0] raw_hits = {dbg_hit, hit3, hit2, hit1, hit0};
    // Each enable gates only its own zone; zone 1 and 3 never need 0 and 2 on
    wire logic [4:0] zone_nxt = io_req ? (raw_hits & cfg_r[4:0] & ext_chip_selects) : 5'h00;

    always_ff @(posedge aclk)
    begin
        main_sync_r <= {main_sync_r[0], main_power_up_reset};
        stby_sync_r <= {stby_sync_r[0], standby_power_up_reset};
    end

    // Map registers: reset clears all, lock freezes all but the release path
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_r    <= `XZD_CFG_RESET;
            a_high_r <= 8'h00;
            a_low_r  <= 8'h00;
            a_size_r <= 8'h00;
            b_high_r <= 8'h00;
            b_low_r  <= 8'h00;
            b_size_r <= 8'h00;
        end
        else
        begin
            cfg_r <= cfg_fin;
            if (map_wr && aw_idx_r == `XZD_IDX_A_BASE_HIGH) a_high_r <= wbyte_r;
            if (map_wr && aw_idx_r == `XZD_IDX_A_BASE_LOW)  a_low_r  <= wbyte_r;
            if (map_wr && aw_idx_r == `XZD_IDX_A_SIZE)      a_size_r <= wbyte_r & `XZD_SIZE_WR_MASK;
            if (map_wr && aw_idx_r == `XZD_IDX_B_BASE_HIGH) b_high_r <= wbyte_r;
            if (map_wr && aw_idx_r == `XZD_IDX_B_BASE_LOW)  b_low_r  <= wbyte_r;
            if (map_wr && aw_idx_r == `XZD_IDX_B_SIZE)      b_size_r <= wbyte_r & `XZD_SIZE_WR_MASK;
        end
    end

    // Lock control sits outside the lock so the unlock path always works
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            stby_sel_r <= 1'b0;
        else if (wr_en && aw_idx_r == `XZD_IDX_LOCK_CTL)
            stby_sel_r <= wbyte_r[`XZD_STBY_SEL_BIT];
    end

    // Write channel: address and data taken in any order, one write at a time
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_state_r <= XZD_WR_COLLECT;
            aw_done_r  <= 1'b0;
            w_done_r   <= 1'b0;
            awready_r  <= 1'b1;
            wready_r   <= 1'b1;
            aw_idx_r   <= 8'h00;
            wbyte_r    <= 8'h00;
            wlane_r    <= 1'b0;
            bresp_r    <= `XZD_RESP_OKAY;
        end
        else
        begin
            if (aw_hs)
            begin
                aw_done_r <= 1'b1;
                awready_r <= 1'b0;
                aw_idx_r  <= (s_axi_awaddr[11:10] == 2'h0 && s_axi_awaddr[1:0] == 2'h0) ? s_axi_awaddr[9:2] : 8'h00;
            end
            if (w_hs)
            begin
                w_done_r <= 1'b1;
                wready_r <= 1'b0;
                wbyte_r  <= s_axi_wdata[7:0];
                wlane_r  <= s_axi_wstrb[0];
            end
            case (wr_state_r)
                XZD_WR_COLLECT:
                    if (wr_fire)
                    begin
                        wr_state_r <= XZD_WR_RESP;
                        bresp_r    <= aw_ok ? `XZD_RESP_OKAY : `XZD_RESP_SLVERR;
                    end
                XZD_WR_RESP:
                    if (b_hs)
                    begin
                        wr_state_r <= XZD_WR_COLLECT;
                        aw_done_r  <= 1'b0;
                        w_done_r   <= 1'b0;
                        awready_r  <= 1'b1;
                        wready_r   <= 1'b1;
                    end
                default:
                    wr_state_r <= XZD_WR_COLLECT;
            endcase
        end
    end

    // Read channel: answer one cycle after the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= `XZD_RESP_OKAY;
        end
        else if (ar_hs)
        begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= {24'h000000, rd_byte};
            rresp_r   <= ar_ok ? `XZD_RESP_OKAY : `XZD_RESP_SLVERR;
        end
        else if (r_hs)
        begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            zone_sel_r <= 5'h00;
            io_fwd_r   <= 1'b0;
        end
        else
        begin
            zone_sel_r <= zone_nxt;
            io_fwd_r   <= |zone_nxt;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = wr_state_r[1];
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign zone_select   = zone_sel_r;
    assign io_forward    = io_fwd_r;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    rst_clears_cfg_a: assert property (disable iff (1'b0) !aresetn |=> cfg_r == 8'h00)
        else $error("config not cleared by reset");
    lock_freezes_a: assert property (locked && !lock_clr |=> $stable(cfg_r) && $stable(a_high_r) && $stable(b_size_r))
        else $error("locked map register changed");
    por_release_a: assert property (por_release |=> !cfg_r[7])
        else $error("lock survived selected power-up reset");
    unlock_clears_a: assert property (unlock_wr |=> !cfg_r[7])
        else $error("lock survived external unlock");
    debug_fwd_a: assert property (io_req && io_addr == 16'h0080 && cfg_r[4] && ext_chip_selects[4] |=> zone_select[4] && io_forward)
        else $error("debug port access not forwarded");
    debug_off_a: assert property (!cfg_r[4] |=> !zone_select[4])
        else $error("debug port forwarded while disabled");
    zone0_hit_a: assert property (io_req && cfg_r[0] && ext_chip_selects[0] && a_size_r == 8'h00 && io_addr == {a_high_r, a_low_r} |=> zone_select[0])
        else $error("zone 0 base access missed");
    zone1_hit_a: assert property (io_req && cfg_r[1] && !cfg_r[0] && ext_chip_selects[1] && a_size_r == 8'h00 && io_addr == {a_high_r, a_low_r} + 16'h0001 |=> zone_select[1] && io_forward)
        else $error("zone 1 missed without zone 0");
    zone2_hit_a: assert property (io_req && cfg_r[2] && ext_chip_selects[2] && b_size_r == 8'h02 && io_addr == ({b_high_r, b_low_r} | 16'h0003) |=> zone_select[2])
        else $error("zone 2 span access missed");
    zone3_hit_a: assert property (io_req && cfg_r[3] && !cfg_r[2] && ext_chip_selects[3] && b_size_r == 8'h02 && {b_low_r[1:0]} == 2'h0 && io_addr == {b_high_r, b_low_r} + 16'h0004 |=> zone_select[3])
        else $error("zone 3 missed without zone 2");
    size_rsvd_a: assert property (a_size_r[3:0] > 4'h8 |=> !zone_select[0] && !zone_select[1])
        else $error("reserved size decoded");
    no_cs_a: assert property (io_req && (cfg_r[4:0] & ext_chip_selects) == 5'h00 |=> !io_forward)
        else $error("zone without chip select responded");
    rsvd_zero_a: assert property (cfg_r[6:5] == 2'h0)
        else $error("reserved config bits nonzero");
    rd_latency_a: assert property (ar_hs |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");

    lock_set_c: cover property (wr_en && aw_idx_r == `XZD_IDX_CFG && wbyte_r[7] && !locked);
    locked_wr_c: cover property (wr_en && locked && aw_idx_r == `XZD_IDX_A_BASE_LOW);
    zone3_c: cover property (zone_select[3]);
    unlock_c: cover property (locked ##1 unlock_wr);

endmodule : xzd_io_zone_decode

`default_nettype wire

/* File: hw/xzd_defines.svh */
// Register indices, field positions, reset values and fixed addresses of the I/O zone decode block.
// Assumes byte address = 4 * index on the register bus.
`ifndef XZD_DEFINES_SVH
`define XZD_DEFINES_SVH

`define XZD_IDX_CFG          8'hf0
`define XZD_IDX_A_BASE_HIGH  8'hf1
`define XZD_IDX_A_BASE_LOW   8'hf2
`define XZD_IDX_A_SIZE       8'hf3
`define XZD_IDX_B_BASE_HIGH  8'hf4
`define XZD_IDX_B_BASE_LOW   8'hf5
`define XZD_IDX_B_SIZE       8'hf6
`define XZD_IDX_LOCK_CTL     8'h20

`define XZD_CFG_RESET        8'h00
`define XZD_CFG_WR_MASK      8'h9f
`define XZD_SIZE_WR_MASK     8'h0f
`define XZD_LOCK_BIT         7
`define XZD_DEBUG_BIT        4
`define XZD_UNLOCK_BIT       0
`define XZD_STBY_SEL_BIT     1
`define XZD_SIZE_MAX         4'h8
`define XZD_DEBUG_PORT_ADDR  16'h0080

`define XZD_RESP_OKAY        2'h0
`define XZD_RESP_SLVERR      2'h2

`endif

/* File: hw/xzd_pkg.sv */
// Types shared by the I/O zone decode block.
// Assumes nothing of its surroundings.
package xzd_pkg;

    typedef logic [7:0] xzd_byte_t;

    typedef enum logic [1:0]
    {
        XZD_WR_COLLECT = 2'b01,
        XZD_WR_RESP    = 2'b10
    } xzd_wr_state_t;

endpackage : xzd_pkg

/* File: hw/xzd_zone_pair.sv */
// Address match for one base/size pair: a lower zone and the zone right above it.
// Assumes a size above 8 is reserved; such a pair matches nothing.
`timescale 1ns/100ps
`default_nettype none
`include "xzd_defines.svh"

module xzd_zone_pair
    import xzd_pkg::*;
(
    input  wire logic [7:0]  base_high,
    input  wire logic [7:0]  base_low,
    input  wire logic [3:0]  size_exp,
    input  wire logic [15:0] io_addr,
    output logic             hit_lower,
    output logic             hit_upper
);

    function automatic logic span_hit(input logic [15:0] addr, input logic [15:0] start, input logic [3:0] n);
        logic [15:0] keep;
        keep = 16'hffff << n;
        return (addr & keep) == (start & keep);
    endfunction : span_hit

    wire logic [15:0] start_lower = {base_high, base_low};
    wire logic [15:0] span        = 16'h0001 << size_exp;
    wire logic [15:0] start_upper = start_lower + span;
    wire logic        size_ok     = size_exp <= `XZD_SIZE_MAX;

    assign hit_lower = size_ok && span_hit(io_addr, start_lower, size_exp);
    assign hit_upper = size_ok && span_hit(io_addr, start_upper, size_exp);

endmodule : xzd_zone_pair

`default_nettype wire

/* File: sim/xzd_io_host_model.sv */
// Far-side model: host that issues I/O cycles and extension-bus logic that maps chip selects.
// Assumes calls are made just after a rising edge of aclk.
`timescale 1ns/100ps
`default_nettype none

module xzd_io_host_model
(
    input  wire logic       aclk,
    output var logic        io_req,
    output var logic [15:0] io_addr,
    output var logic [4:0]  ext_chip_selects
);
    initial
    begin
        io_req = 1'b0;
        io_addr = 16'hffff;
        ext_chip_selects = 5'h1f;
    end

    // Address is not held after the cycle, so show its inverse instead of a stale copy
    task automatic cycle(input logic [15:0] a);
        io_req <= 1'b1;
        io_addr <= a;
        @(posedge aclk);
        io_req <= 1'b0;
        io_addr <= ~a;
    endtask : cycle

    task automatic map_cs(input logic [4:0] m);
        ext_chip_selects <= m;
    endtask : map_cs
endmodule : xzd_io_host_model

`default_nettype wire

/* File: sim/xzd_io_zone_decode_tb.sv */
// Self-checking bench: AXI4-Lite register tasks plus host I/O cycles through the far-side model.
// Assumes the register byte address is four times the index.
`timescale 1ns/100ps
`default_nettype none
`include "xzd_defines.svh"

module xzd_io_zone_decode_tb;
    import xzd_pkg::*;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, main_por, stby_por, io_req, io_forward;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [15:0] io_addr;
    logic [4:0]  cs, zone_select;
    int          num_errors, checked;

    xzd_io_zone_decode dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .main_power_up_reset(main_por),
        .standby_power_up_reset(stby_por), .io_req(io_req), .io_addr(io_addr), .ext_chip_selects(cs),
        .zone_select(zone_select), .io_forward(io_forward));
    xzd_io_host_model io_u (.aclk(aclk), .io_req(io_req), .io_addr(io_addr), .ext_chip_selects(cs));

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_data

    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("FAIL at %0t: response %h expected %h", $time, got, exp);
        end
    endtask : check_resp

    task automatic timed_out();
        num_errors++;
        $display("FAIL at %0t: handshake timeout, got %h expected %h", $time, 1'b0, 1'b1);
        conclude();
    endtask : timed_out

    function automatic logic [11:0] ba(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction : ba

    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
        logic ha, hw, hb;
        int   n;
        n = 0;
        awaddr <= ba(idx);
        wdata <= {24'h0, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(negedge aclk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid && bready;
            if (hb)
                check_resp(bresp, er);
            @(posedge aclk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            n++;
        end
        while (!hb && n < 50);
        if (!hb) timed_out();
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [7:0] ed, input logic [1:0] er);
        logic ha, hr;
        int   n;
        n = 0;
        araddr <= ba(idx);
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(negedge aclk);
            ha = arvalid && arready;
            hr = rvalid && rready;
            if (hr)
            begin
                check_data(rdata, {24'h0, ed});
                check_resp(rresp, er);
            end
            @(posedge aclk);
            if (ha) arvalid <= 1'b0;
            n++;
        end
        while (!hr && n < 50);
        if (!hr) timed_out();
    endtask : rd

    // Select is registered, so look one edge after the request, inside the cycle it stands
    task automatic io_chk(input logic [15:0] a, input logic [4:0] exp);
        io_u.cycle(a);
        #1;
        check_data({27'h0, zone_select}, {27'h0, exp});
        check_data({31'h0, io_forward}, {31'h0, |exp});
    endtask : io_chk

    task automatic por_pulse(input logic stby);
        if (stby) stby_por <= 1'b1; else main_por <= 1'b1;
        repeat (4) @(posedge aclk);
        stby_por <= 1'b0;
        main_por <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask : por_pulse

    task automatic test_end(input string name);
        $display("Test %s done, mismatches so far %0d", name, num_errors);
    endtask : test_end

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, main_por, stby_por} = 8'h0;
        awaddr = 12'h0; araddr = 12'h0; wdata = 32'h0; wstrb = 4'h0;
        num_errors = 0; checked = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 7; i++)
            rd(`XZD_IDX_CFG + i[7:0], 8'h00, `XZD_RESP_OKAY);
        rd(`XZD_IDX_LOCK_CTL, 8'h00, `XZD_RESP_OKAY);
        rd(8'h40, 8'h00, `XZD_RESP_SLVERR);
        wr(8'h40, 8'h55, 4'h1, `XZD_RESP_SLVERR);
        test_end("reset");
        // Aligned bases only: 0300 for 8-byte zones, 0400 for 1-byte zones
        wr(`XZD_IDX_A_BASE_HIGH, 8'h03, 4'h1, `XZD_RESP_OKAY);
        wr(`XZD_IDX_A_SIZE, 8'hf3, 4'h1, `XZD_RESP_OKAY);
        rd(`XZD_IDX_A_SIZE, 8'h03, `XZD_RESP_OKAY);
        wr(`XZD_IDX_B_BASE_HIGH, 8'h04, 4'h1, `XZD_RESP_OKAY);
        wr(`XZD_IDX_CFG, 8'h7f, 4'h1, `XZD_RESP_OKAY);
        rd(`XZD_IDX_CFG, 8'h1f, `XZD_RESP_OKAY);
        io_chk(16'h0300, 5'h01);
        io_chk(16'h0307, 5'h01);
        io_chk(16'h0308, 5'h02);
        io_chk(16'h030f, 5'h02);
        io_chk(16'h0310, 5'h00);
        io_chk(16'h02ff, 5'h00);
        io_chk(16'h0400, 5'h04);
        io_chk(16'h0401, 5'h08);
        io_chk(16'h0402, 5'h00);
        io_chk(16'h0080, 5'h10);
        io_chk(16'h0081, 5'h00);
        io_u.map_cs(5'h0e);
        io_chk(16'h0300, 5'h00);
        io_chk(16'h0080, 5'h00);
        io_chk(16'h0308, 5'h02);
        io_u.map_cs(5'h1f);
        wr(`XZD_IDX_CFG, 8'h0a, 4'h1, `XZD_RESP_OKAY);
        io_chk(16'h0300, 5'h00);
        io_chk(16'h0308, 5'h02);
        io_chk(16'h0400, 5'h00);
        io_chk(16'h0401, 5'h08);
        io_chk(16'h0080, 5'h00);
        wr(`XZD_IDX_A_BASE_HIGH, 8'h02, 4'h1, `XZD_RESP_OKAY);
        wr(`XZD_IDX_A_SIZE, 8'h08, 4'h1, `XZD_RESP_OKAY);
        wr(`XZD_IDX_CFG, 8'h0f, 4'h1, `XZD_RESP_OKAY);
        io_chk(16'h02ff, 5'h01);
        io_chk(16'h0300, 5'h02);
        io_chk(16'h03ff, 5'h02);
        io_chk(16'h0400, 5'h04);
        wr(`XZD_IDX_CFG, 8'h00, 4'h0, `XZD_RESP_OKAY);
        rd(`XZD_IDX_CFG, 8'h0f, `XZD_RESP_OKAY);
        test_end("decode");
        wr(`XZD_IDX_CFG, 8'h9f, 4'h1, `XZD_RESP_OKAY);
        rd(`XZD_IDX_CFG, 8'h9f, `XZD_RESP_OKAY);
        wr(`XZD_IDX_CFG, 8'h00, 4'h1, `XZD_RESP_OKAY);
        rd(`XZD_IDX_CFG, 8'h9f, `XZD_RESP_OKAY);
        for (int i = 1; i < 7; i++)
        begin
            wr(`XZD_IDX_CFG + i[7:0], 8'h05, 4'h1, `XZD_RESP_OKAY);
            rd(`XZD_IDX_CFG + i[7:0], (i == 1) ? 8'h02 : (i == 3) ? 8'h08 : (i == 4) ? 8'h04 : 8'h00,
               `XZD_RESP_OKAY);
        end
        io_chk(16'h0080, 5'h10);
        wr(`XZD_IDX_LOCK_CTL, 8'h01, 4'h1, `XZD_RESP_OKAY);
        rd(`XZD_IDX_CFG, 8'h1f, `XZD_RESP_OKAY);
        rd(`XZD_IDX_LOCK_CTL, 8'h00, `XZD_RESP_OKAY);
        test_end("lock");
        wr(`XZD_IDX_CFG, 8'h9f, 4'h1, `XZD_RESP_OKAY);
        por_pulse(1'b1);
        rd(`XZD_IDX_CFG, 8'h9f, `XZD_RESP_OKAY);
        por_pulse(1'b0);
        rd(`XZD_IDX_CFG, 8'h1f, `XZD_RESP_OKAY);
        wr(`XZD_IDX_LOCK_CTL, 8'h02, 4'h1, `XZD_RESP_OKAY);
        rd(`XZD_IDX_LOCK_CTL, 8'h02, `XZD_RESP_OKAY);
        wr(`XZD_IDX_CFG, 8'h9f, 4'h1, `XZD_RESP_OKAY);
        por_pulse(1'b0);
        rd(`XZD_IDX_CFG, 8'h9f, `XZD_RESP_OKAY);
        por_pulse(1'b1);
        rd(`XZD_IDX_CFG, 8'h1f, `XZD_RESP_OKAY);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`XZD_IDX_CFG, 8'h00, `XZD_RESP_OKAY);
        io_chk(16'h0080, 5'h00);
        test_end("power_up");
        conclude();
    end
endmodule : xzd_io_zone_decode_tb

`default_nettype wire
